// file: arch_regfile_pkg.sv
/*
 * Shared constants and carrier types for the architected register file:
 * register map, field positions, reset values and the request structs.
 * Assumes one core clock; all users reference items as arch_regfile_pkg::name.
 */
package arch_regfile_pkg;
    // array geometry
    localparam int NUM_GPR = 32;
    localparam int GPR_W = 32;
    localparam int NUM_FPR = 32;
    localparam int FPR_W = 64;
    localparam int NUM_SEG = 16;
    localparam int REG_W = 32;
    localparam int CR_FIELD_W = 4;
    localparam int ADDR_W = 8;

    // register map, byte addresses on the plain register port
    localparam logic [7:0] OFS_CR = 8'h00;
    localparam logic [7:0] OFS_FLOAT_STATUS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_MSR = 8'h08;
    localparam logic [7:0] OFS_MSR_SAVE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_IMPL0 = 8'h18;
    localparam logic [7:0] OFS_IMPL1 = 8'h1C;
    localparam logic [7:0] OFS_SEG_BASE = 8'h40;
    localparam logic [7:0] OFS_SEG_LAST = 8'h7C;

    // reset values
    localparam logic [31:0] CR_RESET = 32'h0000_0000;
    localparam logic [31:0] FLOAT_STATUS_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] MSR_RESET = 32'h0000_0000;
    localparam logic [31:0] IMPL_RESET = 32'h0000_0000;
    localparam logic [3:0] IMPL_TAG_DEFAULT = 4'h1; // arbitrary identification tag

    // machine state word: privilege bit (1 = user)
    localparam int MSR_PR_POS = 14;

    // float status/control layout
    localparam int FLOAT_STATUS_CONTROL_FX_POS = 31;
    localparam int FLOAT_STATUS_CONTROL_FEX_POS = 30;
    localparam int FLOAT_STATUS_CONTROL_EXC_LSB = 25;
    localparam int FLOAT_STATUS_CONTROL_EXC_W = 5;
    localparam int FLOAT_STATUS_CONTROL_EN_LSB = 3;
    localparam int FLOAT_STATUS_CONTROL_RN_LSB = 0;
    localparam int FLOAT_STATUS_CONTROL_RN_W = 2;

    // interrupt status / mask bits
    localparam int IRQ_W = 3;
    localparam int IRQ_PRIV_POS = 0;
    localparam int IRQ_EXC_POS = 1;
    localparam int IRQ_FP_POS = 2;

    // segment entry layout; type bit is the most significant bit
    localparam int SEG_TYPE_POS = 31;
    localparam int SEG_KS_POS = 30;
    localparam int SEG_KP_POS = 29;
    localparam int SEG_N_POS = 28;
    localparam int SEG_BUID_LSB = 20;
    localparam int SEG_BUID_W = 9;
    localparam int SEG_VSID_W = 24;
    localparam int SEG_CTRL_W = 20;

    typedef logic [4:0] reg_idx_t;
    typedef logic [3:0] seg_idx_t;

    typedef struct packed {
        reg_idx_t src_a;
        reg_idx_t src_b;
        logic use_imm;
        logic [31:0] imm;
    } gpr_rd_req_t;

    typedef struct packed {
        logic en;
        reg_idx_t dst;
        logic [31:0] data;
    } gpr_wr_t;

    typedef struct packed {
        reg_idx_t src;
        reg_idx_t dst_unused;
    } fpr_rd_req_t;

    typedef struct packed {
        logic en;
        reg_idx_t dst;
        logic dbl;
        logic [63:0] data;
    } fpr_wr_t;

    typedef struct packed {
        logic dbl;
        logic [63:0] data;
    } fpr_val_t;

    typedef struct packed {
        logic en;
        logic [2:0] field;
        logic [3:0] value;
    } cr_upd_t;

    typedef enum logic [1:0] {PK_MSR_WRITE, PK_SEG_WRITE, PK_TRANSLATION, PK_OTHER} priv_kind_t;

    typedef struct packed {
        logic valid;
        priv_kind_t kind;
        seg_idx_t idx;
        logic [31:0] data;
    } priv_req_t;

    typedef struct packed {
        logic io_seg;
        logic ks;
        logic kp;
        logic no_exec;
        logic [23:0] vsid;
        logic [8:0] bus_unit;
        logic [19:0] ctrl;
    } seg_view_t;
endpackage

// file: arch_regfile.sv
/*
 * Architected register set of a 32-bit superscalar core: integer and float
 * arrays, condition fields, float status/control, machine state with exception
 * save/restore, segment entries, implementation registers and privilege checks.
 * Assumes every input comes from logic on CLK_SYS_IN; no synchronisers needed.
 */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

// Function
// - thirty-two integer registers, 32 bits each
// - integer operands read, results written here
// - thirty-two 64-bit float registers for operands
// - float entries hold single or double format
// - condition word: eight 4-bit fields, updated, tested
// - two sources plus separate target register
// - operand from register or instruction immediate
// - float status: flags, summaries, enables, rounding
// - 32-bit machine state, supervisor access only
// - save machine state on exception, restore after
// - exactly two privilege levels: supervisor, user
// - state-changing instructions only in supervisor mode
// - sixteen 32-bit segment registers
// - segment layout chosen by most significant bit
// - no time base; own implementation registers
// - privilege taken from machine state privilege bit
module arch_regfile (
    input wire logic CLK_SYS_IN, // core clock, 40 MHz
    input wire logic RST_N_IN, // async reset, active low
    input wire logic [7:0] REG_ADDR_IN, // register port byte address
    input wire logic [31:0] REG_WDATA_IN, // register port write data
    input wire logic REG_WR_IN, // register write strobe
    input wire logic REG_RD_IN, // register read strobe
    output logic [31:0] REG_RDATA_OUT, // read data, cycle after strobe
    input wire arch_regfile_pkg::gpr_rd_req_t GPR_RD_IN, // integer operand request
    output logic [31:0] GPR_OP_A_OUT, // operand a, next cycle
    output logic [31:0] GPR_OP_B_OUT, // operand b or immediate
    input wire arch_regfile_pkg::gpr_wr_t GPR_WR_IN, // integer result write
    input wire arch_regfile_pkg::reg_idx_t FPR_RD_IDX_IN, // float operand index
    output arch_regfile_pkg::fpr_val_t FPR_OP_OUT, // float operand with format
    input wire arch_regfile_pkg::fpr_wr_t FPR_WR_IN, // float result write
    input wire arch_regfile_pkg::cr_upd_t CR_UPD_IN, // condition field update
    input wire logic [4:0] CR_TEST_BIT_IN, // condition bit for branch test
    output logic CR_TEST_OUT, // tested bit, next cycle
    input wire logic [4:0] FP_EXC_IN, // float exception pulses
    output logic [1:0] FP_ROUND_OUT, // rounding control
    input wire logic EXC_TAKE_IN, // exception taken pulse
    input wire logic EXC_RETURN_IN, // exception return pulse
    input wire arch_regfile_pkg::priv_req_t PRIV_REQ_IN, // privileged instruction
    output logic PRIV_GRANT_OUT, // privileged request granted, supervisor mode
    output logic PRIV_VIOL_OUT, // privilege violation pulse
    output logic USER_MODE_OUT, // 1 while at user privilege
    input wire arch_regfile_pkg::seg_idx_t SEG_SEL_IN, // segment to decode
    output arch_regfile_pkg::seg_view_t SEG_VIEW_OUT, // decoded segment entry
    output logic IRQ_OUT // level interrupt
);
    logic [31:0] gpr_r [arch_regfile_pkg::NUM_GPR];
    logic [63:0] fpr_r [arch_regfile_pkg::NUM_FPR];
    logic [arch_regfile_pkg::NUM_FPR-1:0] fpr_dbl_r;
    logic [31:0] seg_r [arch_regfile_pkg::NUM_SEG];
    logic [31:0] cr_r;
    logic [31:0] float_status_control_r;
    logic [31:0] msr_r;
    logic [31:0] msr_save_r;
    logic [31:0] impl0_r;
    logic [31:0] impl1_r;
    logic [arch_regfile_pkg::IRQ_W-1:0] irq_stat_r;
    logic [arch_regfile_pkg::IRQ_W-1:0] irq_mask_r;
    logic fex_prev_r;

    // privilege decode: two levels, one bit decides
    wire user_mode = msr_r[arch_regfile_pkg::MSR_PR_POS];

    // register port address decode
    wire hit_cr = (REG_ADDR_IN == arch_regfile_pkg::OFS_CR);
    wire hit_float_status_control = (REG_ADDR_IN == arch_regfile_pkg::OFS_FLOAT_STATUS_CONTROL);
    wire hit_msr = (REG_ADDR_IN == arch_regfile_pkg::OFS_MSR);
    wire hit_msr_save = (REG_ADDR_IN == arch_regfile_pkg::OFS_MSR_SAVE);
    wire hit_stat = (REG_ADDR_IN == arch_regfile_pkg::OFS_IRQ_STAT);
    wire hit_mask = (REG_ADDR_IN == arch_regfile_pkg::OFS_IRQ_MASK);
    wire hit_impl0 = (REG_ADDR_IN == arch_regfile_pkg::OFS_IMPL0);
    wire hit_impl1 = (REG_ADDR_IN == arch_regfile_pkg::OFS_IMPL1);
    wire hit_seg = (REG_ADDR_IN >= arch_regfile_pkg::OFS_SEG_BASE) &&
                   (REG_ADDR_IN <= arch_regfile_pkg::OFS_SEG_LAST) && (REG_ADDR_IN[1:0] == 2'h0);
    wire [3:0] seg_bus_idx = REG_ADDR_IN[5:2];
    // supervisor-only items: machine state, its save copy, segments, implementation regs
    wire hit_super = hit_msr | hit_msr_save | hit_seg | hit_impl0 | hit_impl1;
    wire bus_access = REG_WR_IN | REG_RD_IN;
    wire bus_viol = bus_access & hit_super & user_mode;
    wire bus_wr_ok = REG_WR_IN & ~(hit_super & user_mode);

    // privileged instruction check
    wire priv_ok = PRIV_REQ_IN.valid & ~user_mode;
    wire priv_viol = PRIV_REQ_IN.valid & user_mode;
    wire priv_msr_wr = priv_ok & (PRIV_REQ_IN.kind == arch_regfile_pkg::PK_MSR_WRITE);
    wire priv_seg_wr = priv_ok & (PRIV_REQ_IN.kind == arch_regfile_pkg::PK_SEG_WRITE);

    // operand b selection: register or immediate
    wire [31:0] op_b_sel = GPR_RD_IN.use_imm ? GPR_RD_IN.imm : gpr_r[GPR_RD_IN.src_b];

    // float status summaries
    wire [4:0] fp_flags = float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_EXC_LSB +: arch_regfile_pkg::FLOAT_STATUS_CONTROL_EXC_W];
    wire [4:0] fp_enables = float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_EN_LSB +: arch_regfile_pkg::FLOAT_STATUS_CONTROL_EXC_W];
    wire [4:0] fp_flags_nxt = fp_flags | FP_EXC_IN;
    wire fex_nxt = |(fp_flags_nxt & fp_enables);

    // segment decode: type bit selects the meaning of the rest
    wire [31:0] seg_sel_word = seg_r[SEG_SEL_IN];
    wire seg_io = seg_sel_word[arch_regfile_pkg::SEG_TYPE_POS];

    // condition field write mask from the update port
    wire [4:0] cr_lsb = 5'(5'd28 - {CR_UPD_IN.field, 2'b00});
    wire [31:0] cr_field_mask = 32'(4'hF) << cr_lsb;
    wire [31:0] cr_field_val = 32'(CR_UPD_IN.value) << cr_lsb;

    // read mux for the register port; unmapped reads give zero
    wire [31:0] stat_word = 32'(irq_stat_r);
    wire [31:0] mask_word = 32'(irq_mask_r);
    wire [31:0] rd_mux = bus_viol ? 32'h0000_0000 :
                         hit_cr ? cr_r :
                         hit_float_status_control ? float_status_control_r :
                         hit_msr ? msr_r :
                         hit_msr_save ? msr_save_r :
                         hit_stat ? stat_word :
                         hit_mask ? mask_word :
                         hit_impl0 ? impl0_r :
                         hit_impl1 ? impl1_r :
                         hit_seg ? seg_r[seg_bus_idx] : 32'h0000_0000;

    // events feeding the interrupt status
    wire [arch_regfile_pkg::IRQ_W-1:0] irq_evt;
    assign irq_evt[arch_regfile_pkg::IRQ_PRIV_POS] = bus_viol | priv_viol;
    assign irq_evt[arch_regfile_pkg::IRQ_EXC_POS] = EXC_TAKE_IN;
    assign irq_evt[arch_regfile_pkg::IRQ_FP_POS] = fex_nxt & ~fex_prev_r;
    wire [arch_regfile_pkg::IRQ_W-1:0] irq_clr = (REG_WR_IN && hit_stat) ?
                                                 REG_WDATA_IN[arch_regfile_pkg::IRQ_W-1:0] : '0;
    // set wins over a same-cycle write-one-to-clear
    wire [arch_regfile_pkg::IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

    // integer array: one write port; reads registered so a write shows next cycle
    always_ff @(posedge CLK_SYS_IN) begin
        if (GPR_WR_IN.en) begin
            gpr_r[GPR_WR_IN.dst] <= GPR_WR_IN.data;
        end
    end

    // float array with a per-entry format tag
    always_ff @(posedge CLK_SYS_IN) begin
        if (FPR_WR_IN.en) begin
            fpr_r[FPR_WR_IN.dst] <= FPR_WR_IN.data;
        end
    end

    // format tags reset to double so stale entries read a defined format
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fpr_dbl_r <= '1;
        end else if (FPR_WR_IN.en) begin
            fpr_dbl_r[FPR_WR_IN.dst] <= FPR_WR_IN.dbl;
        end
    end

    // segment entries, writable by privileged instruction or supervisor bus write
    always_ff @(posedge CLK_SYS_IN) begin
        if (priv_seg_wr) begin
            seg_r[PRIV_REQ_IN.idx] <= PRIV_REQ_IN.data;
        end else if (bus_wr_ok && hit_seg) begin
            seg_r[seg_bus_idx] <= REG_WDATA_IN;
        end
    end

    // operand outputs; both read ports serve one instruction each cycle
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            GPR_OP_A_OUT <= 32'h0000_0000;
            GPR_OP_B_OUT <= 32'h0000_0000;
            FPR_OP_OUT <= '0;
        end else begin
            GPR_OP_A_OUT <= gpr_r[GPR_RD_IN.src_a];
            GPR_OP_B_OUT <= op_b_sel;
            FPR_OP_OUT <= {fpr_dbl_r[FPR_RD_IDX_IN], fpr_r[FPR_RD_IDX_IN]};
        end
    end

    // condition word: execution update has priority over a software write
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cr_r <= arch_regfile_pkg::CR_RESET;
            CR_TEST_OUT <= 1'b0;
        end else begin
            if (CR_UPD_IN.en) begin
                cr_r <= (cr_r & ~cr_field_mask) | cr_field_val;
            end else if (REG_WR_IN && hit_cr) begin
                cr_r <= REG_WDATA_IN;
            end
            CR_TEST_OUT <= cr_r[5'(5'd31 - CR_TEST_BIT_IN)];
        end
    end

    // float status: sticky flags, summaries recomputed every cycle without a register port write to it
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            float_status_control_r <= arch_regfile_pkg::FLOAT_STATUS_CONTROL_RESET;
            fex_prev_r <= 1'b0;
        end else begin
            if (REG_WR_IN && hit_float_status_control) begin
                float_status_control_r <= REG_WDATA_IN;
            end else begin
                float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_EXC_LSB +: arch_regfile_pkg::FLOAT_STATUS_CONTROL_EXC_W] <= fp_flags_nxt;
                float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_FX_POS] <= float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_FX_POS] | (|FP_EXC_IN);
                float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_FEX_POS] <= fex_nxt;
            end
            fex_prev_r <= fex_nxt;
        end
    end

    // machine state: exception entry saves and drops to supervisor, return restores
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            msr_r <= arch_regfile_pkg::MSR_RESET;
            msr_save_r <= arch_regfile_pkg::MSR_RESET;
        end else if (EXC_TAKE_IN) begin
            msr_save_r <= msr_r;
            msr_r[arch_regfile_pkg::MSR_PR_POS] <= 1'b0;
        end else if (EXC_RETURN_IN) begin
            msr_r <= msr_save_r;
        end else if (priv_msr_wr) begin
            msr_r <= PRIV_REQ_IN.data;
        end else if (bus_wr_ok && hit_msr) begin
            msr_r <= REG_WDATA_IN;
        end else if (bus_wr_ok && hit_msr_save) begin
            msr_save_r <= REG_WDATA_IN;
        end
    end

    // implementation registers replace the absent time base
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            impl0_r <= arch_regfile_pkg::IMPL_RESET;
            impl1_r <= {28'h000_0000, arch_regfile_pkg::IMPL_TAG_DEFAULT};
        end else if (bus_wr_ok && hit_impl0) begin
            impl0_r <= REG_WDATA_IN;
        end else if (bus_wr_ok && hit_impl1) begin
            impl1_r <= REG_WDATA_IN;
        end
    end

    // interrupt status, mask and level output
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            IRQ_OUT <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (REG_WR_IN && hit_mask) begin
                irq_mask_r <= REG_WDATA_IN[arch_regfile_pkg::IRQ_W-1:0];
            end
            IRQ_OUT <= |(irq_stat_nxt & ((REG_WR_IN && hit_mask) ?
                         REG_WDATA_IN[arch_regfile_pkg::IRQ_W-1:0] : irq_mask_r));
        end
    end

    // port answers: read data, grants, violations, mode and segment view
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REG_RDATA_OUT <= 32'h0000_0000;
            PRIV_GRANT_OUT <= 1'b0;
            PRIV_VIOL_OUT <= 1'b0;
            USER_MODE_OUT <= 1'b0;
            FP_ROUND_OUT <= 2'b00;
            SEG_VIEW_OUT <= '0;
        end else begin
            REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 32'h0000_0000;
            PRIV_GRANT_OUT <= priv_ok;
            PRIV_VIOL_OUT <= bus_viol | priv_viol;
            USER_MODE_OUT <= user_mode;
            FP_ROUND_OUT <= float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_RN_LSB +: arch_regfile_pkg::FLOAT_STATUS_CONTROL_RN_W];
            SEG_VIEW_OUT.io_seg <= seg_io;
            SEG_VIEW_OUT.ks <= seg_sel_word[arch_regfile_pkg::SEG_KS_POS];
            SEG_VIEW_OUT.kp <= seg_sel_word[arch_regfile_pkg::SEG_KP_POS];
            // the two layouts share protection keys; the rest is either/or
            SEG_VIEW_OUT.no_exec <= seg_io ? 1'b0 : seg_sel_word[arch_regfile_pkg::SEG_N_POS];
            SEG_VIEW_OUT.vsid <= seg_io ? 24'h00_0000 : seg_sel_word[arch_regfile_pkg::SEG_VSID_W-1:0];
            SEG_VIEW_OUT.bus_unit <= seg_io ?
                seg_sel_word[arch_regfile_pkg::SEG_BUID_LSB +: arch_regfile_pkg::SEG_BUID_W] : 9'h000;
            SEG_VIEW_OUT.ctrl <= seg_io ? seg_sel_word[arch_regfile_pkg::SEG_CTRL_W-1:0] : 20'h0_0000;
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_exc_entry;
        EXC_TAKE_IN ##1 1'b1;
    endsequence

    property p_gpr_wr_visible;
        logic [4:0] a;
        logic [31:0] d;
        (GPR_WR_IN.en, a = GPR_WR_IN.dst, d = GPR_WR_IN.data) ##1
            (GPR_RD_IN.src_a == a && !(GPR_WR_IN.en && GPR_WR_IN.dst == a)) |=> (GPR_OP_A_OUT == d);
    endproperty
    a_gpr_wr_visible: assert property (p_gpr_wr_visible) else $error("integer write not seen next cycle");

    property p_imm_select;
        GPR_RD_IN.use_imm |=> (GPR_OP_B_OUT == $past(GPR_RD_IN.imm));
    endproperty
    a_imm_select: assert property (p_imm_select) else $error("immediate operand not selected");

    property p_user_msr_blocked;
        (user_mode && REG_WR_IN && hit_msr && !EXC_TAKE_IN && !EXC_RETURN_IN) |=> $stable(msr_r) && PRIV_VIOL_OUT;
    endproperty
    a_user_msr_blocked: assert property (p_user_msr_blocked) else $error("user write changed machine state");

    property p_exc_save;
        logic [31:0] m;
        // the mode output is registered from the bit, so it drops one cycle after the save
        (EXC_TAKE_IN, m = msr_r) |=> (msr_save_r == m) ##1 !USER_MODE_OUT;
    endproperty
    a_exc_save: assert property (p_exc_save) else $error("state not saved on exception");

    property p_exc_restore;
        (EXC_RETURN_IN && !EXC_TAKE_IN) |=> (msr_r == $past(msr_save_r));
    endproperty
    a_exc_restore: assert property (p_exc_restore) else $error("state not restored on return");

    property p_user_priv_refused;
        (PRIV_REQ_IN.valid && user_mode) |=> !PRIV_GRANT_OUT && PRIV_VIOL_OUT ##1 irq_stat_r[arch_regfile_pkg::IRQ_PRIV_POS];
    endproperty
    a_user_priv_refused: assert property (p_user_priv_refused) else $error("user privileged request granted");

    property p_mode_follows_bit;
        s_exc_entry |=> !USER_MODE_OUT;
    endproperty
    a_mode_follows_bit: assert property (p_mode_follows_bit) else $error("mode not from privilege bit");

    property p_cr_field_update;
        CR_UPD_IN.en |=> (cr_r[$past(cr_lsb) +: 4] == $past(CR_UPD_IN.value));
    endproperty
    a_cr_field_update: assert property (p_cr_field_update) else $error("condition field not updated");

    property p_seg_layout;
        seg_io |=> SEG_VIEW_OUT.io_seg && (SEG_VIEW_OUT.vsid == 24'h00_0000);
    endproperty
    a_seg_layout: assert property (p_seg_layout) else $error("segment layout not chosen by type bit");

    property p_fp_summary;
        (FP_EXC_IN != 5'h00 && !(REG_WR_IN && hit_float_status_control)) |=> float_status_control_r[arch_regfile_pkg::FLOAT_STATUS_CONTROL_FX_POS];
    endproperty
    a_fp_summary: assert property (p_fp_summary) else $error("float summary not set");
endmodule

// file: tb.sv
/*
 * self-checking bench for arch_regfile: bench model of integer and condition state; privilege results checked against fixed values.
 * assumes the single 40 MHz core clock and the one-cycle register port of the design.
 */
`timescale 1ns/10ps
module tb;
    logic clk, rst_n, reg_wr, reg_rd, cr_test, exc_take, exc_ret, grant, viol, user_m, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, rdata, op_a, op_b, lfsr_r, cr_m, v, sd;
    logic [4:0] fpr_idx, cr_bit, fp_exc;
    logic [1:0] rnd;
    logic [3:0] seg_sel;
    logic [63:0] fd;
    logic [31:0] gpr_m [32];
    arch_regfile_pkg::gpr_rd_req_t gpr_rd;
    arch_regfile_pkg::gpr_wr_t gpr_wr;
    arch_regfile_pkg::fpr_wr_t fpr_wr;
    arch_regfile_pkg::fpr_val_t fpr_op;
    arch_regfile_pkg::cr_upd_t cr_upd;
    arch_regfile_pkg::priv_req_t priv;
    arch_regfile_pkg::seg_view_t sv;
    int n_mismatch, tests_run;

    arch_regfile u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
        .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .GPR_RD_IN(gpr_rd), .GPR_OP_A_OUT(op_a),
        .GPR_OP_B_OUT(op_b), .GPR_WR_IN(gpr_wr), .FPR_RD_IDX_IN(fpr_idx), .FPR_OP_OUT(fpr_op), .FPR_WR_IN(fpr_wr),
        .CR_UPD_IN(cr_upd), .CR_TEST_BIT_IN(cr_bit), .CR_TEST_OUT(cr_test), .FP_EXC_IN(fp_exc),
        .FP_ROUND_OUT(rnd), .EXC_TAKE_IN(exc_take), .EXC_RETURN_IN(exc_ret), .PRIV_REQ_IN(priv),
        .PRIV_GRANT_OUT(grant), .PRIV_VIOL_OUT(viol), .USER_MODE_OUT(user_m), .SEG_SEL_IN(seg_sel),
        .SEG_VIEW_OUT(sv), .IRQ_OUT(irq));

    // free-running core clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("mismatches %0d, compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // strobes drop right after the taking edge, so back-to-back calls never overlap
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic preq(input arch_regfile_pkg::priv_kind_t k, input logic [3:0] i, input logic [31:0] d);
        @(posedge clk) priv <= '{valid: 1'b1, kind: k, idx: i, data: d};
        @(posedge clk) {priv.valid, seg_sel} <= {1'b0, i};
        #1;
    endtask

    // hang guard: a stuck run still ends in the verdict
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, fpr_idx, cr_bit, fp_exc, exc_take, exc_ret, seg_sel} = '0;
        {gpr_rd, gpr_wr, fpr_wr, cr_upd, priv} = '0;
        {n_mismatch, tests_run, cr_m} = '0;
        lfsr_r = 32'h0000_0030;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk({user_m, viol, grant, irq}, 4'h0);
        // back-to-back writes of all integer entries
        for (int i = 0; i < 32; i++) begin
            lfsr_r = lfsr(lfsr_r);
            gpr_m[i] = lfsr_r;
            @(posedge clk) gpr_wr <= '{en: 1'b1, dst: 5'(i), data: lfsr_r};
        end
        @(posedge clk) gpr_wr.en <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            lfsr_r = lfsr(lfsr_r);
            @(posedge clk) gpr_rd <= '{src_a: 5'(i), src_b: 5'(31 - i), use_imm: i[0], imm: lfsr_r};
            tick(1);
            chk(op_a, gpr_m[i]);
            chk(op_b, i[0] ? lfsr_r : gpr_m[31 - i]);
        end
        // float entries in both formats
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr(lfsr_r);
            fd = {lfsr_r, ~lfsr_r};
            @(posedge clk) fpr_wr <= '{en: 1'b1, dst: 5'(i * 9), dbl: i[0], data: fd};
            @(posedge clk) {fpr_wr.en, fpr_idx} <= {1'b0, 5'(i * 9)};
            tick(1);
            chk(fpr_op, {i[0], fd});
        end
        // every condition field, then branch tests msb first
        for (int f = 0; f < 8; f++) begin
            lfsr_r = lfsr(lfsr_r);
            cr_m[31 - 4 * f -: 4] = lfsr_r[3:0];
            @(posedge clk) cr_upd <= '{en: 1'b1, field: 3'(f), value: lfsr_r[3:0]};
        end
        @(posedge clk) cr_upd.en <= 1'b0;
        for (int b = 0; b < 32; b += 5) begin
            @(posedge clk) cr_bit <= 5'(b);
            tick(1);
            chk(cr_test, cr_m[31 - b]);
        end
        bus_rd(arch_regfile_pkg::OFS_CR, v);
        chk(v, cr_m);
        // float status: rounding, flag with enable, summary, interrupt
        bus_wr(arch_regfile_pkg::OFS_FLOAT_STATUS_CONTROL, 32'h0000_000A);
        tick(1);
        chk(rnd, 2'h2);
        @(posedge clk) fp_exc <= 5'h01;
        @(posedge clk) fp_exc <= 5'h00;
        bus_rd(arch_regfile_pkg::OFS_FLOAT_STATUS_CONTROL, v);
        chk(v, 32'hC200_000A);
        bus_wr(arch_regfile_pkg::OFS_IRQ_MASK, 32'h0000_0007);
        tick(1);
        chk(irq, 1'b1);
        bus_wr(arch_regfile_pkg::OFS_IRQ_STAT, 32'h0000_0004);
        tick(1);
        chk(irq, 1'b0);
        bus_rd(arch_regfile_pkg::OFS_IMPL1, v);
        chk(v, 32'h0000_0001);
        bus_rd(8'h30, v);
        chk(v, 32'h0);
        // segment entries in both layouts, supervisor
        for (int t = 0; t < 2; t++) begin
            lfsr_r = lfsr(lfsr_r);
            sd = {t[0], lfsr_r[30:0]};
            preq(arch_regfile_pkg::PK_SEG_WRITE, 4'(t * 15), sd);
            chk(grant, 1'b1);
            tick(1);
            if (sd[31]) begin
                chk({sv.io_seg, sv.ks, sv.kp, sv.bus_unit, sv.ctrl}, {sd[31:29], sd[28:0]});
            end else begin
                chk({sv.io_seg, sv.ks, sv.kp, sv.no_exec, sv.vsid}, {sd[31:28], sd[23:0]});
            end
        end
        bus_rd(arch_regfile_pkg::OFS_SEG_LAST, v);
        chk(v, sd);
        // user mode: supervisor items refused
        bus_wr(arch_regfile_pkg::OFS_MSR, 32'h0000_4000);
        tick(1);
        chk(user_m, 1'b1);
        bus_rd(arch_regfile_pkg::OFS_MSR, v);
        chk({v, viol}, {32'h0, 1'b1});
        // user write to machine state must be dropped; the saved copy below proves it
        bus_wr(arch_regfile_pkg::OFS_MSR, 32'h0000_0000);
        #1;
        chk({user_m, viol}, 2'b11);
        preq(arch_regfile_pkg::PK_OTHER, 4'h0, 32'h0);
        chk({grant, viol}, 2'b01);
        // exception save then restore
        @(posedge clk) exc_take <= 1'b1;
        @(posedge clk) exc_take <= 1'b0;
        tick(1);
        chk(user_m, 1'b0);
        bus_rd(arch_regfile_pkg::OFS_MSR_SAVE, v);
        chk(v, 32'h0000_4000);
        bus_rd(arch_regfile_pkg::OFS_IRQ_STAT, v);
        chk(v, 32'h0000_0003);
        @(posedge clk) exc_ret <= 1'b1;
        @(posedge clk) exc_ret <= 1'b0;
        tick(1);
        chk(user_m, 1'b1);
        give_verdict;
    end
endmodule
